// file: shared/ppodc_defines.svh
/*
 * Offsets, field positions, reset values and masks for the pad open-drain
 * control block. Assumes a 32-bit Wishbone slave, one register per word.
 */
`ifndef PPODC_DEFINES_SVH
`define PPODC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PPODC_IDX_PADCFG 12'hf3c
`define PPODC_IDX_OD_SER 12'hf40
`define PPODC_IDX_OD_HI 12'hf41
`define PPODC_IDX_OD_CMP 12'hf42
`define PPODC_IDX_PORT 12'hf43
`define PPODC_IDX_LATCH 12'hf44
`define PPODC_IDX_DIR 12'hf45
`define PPODC_IDX_ANCFG 12'hf46

// ----------------------------------------------------------------------------
// Implemented bit masks and reset values
// ----------------------------------------------------------------------------
`define PPODC_MASK_PADCFG 8'h07
`define PPODC_MASK_OD_SER 8'h83
`define PPODC_MASK_OD_HI 8'h0f
`define PPODC_MASK_OD_CMP 8'hff
`define PPODC_RST_CTRL 8'h00
`define PPODC_RST_LATCH 7'h00
`define PPODC_RST_DIR 7'h7f
`define PPODC_RST_ANCFG 7'h00
`define PPODC_ANA_PINS 7'h2f
`define PPODC_OSC_PINS 7'h50

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PPODC_BIT_TTL 0
`define PPODC_RTC_SEL_HI 2
`define PPODC_RTC_SEL_LO 1
`define PPODC_BIT_DELAY_EN 7
`define PPODC_DELAY_PIN 1
`define PPODC_RTC_ALARM 2'h0
`define PPODC_RTC_SEC 2'h1
`define PPODC_RTC_SRC 2'h2

`endif

// file: shared/ppodc_pkg.sv
/*
 * Types for the pad open-drain control block.
 * Assumes ppodc_defines.svh supplies every numeric constant.
 */
package ppodc_pkg;

    // Wishbone classic request bundle from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [13:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ppodc_wb_req_t;

    // Candidate sources for the real-time-clock pin
    typedef struct packed {
        logic alarm;
        logic seconds;
        logic source;
    } ppodc_rtc_src_t;

endpackage

// file: testbench/ppodc_chk.sv
/* Assertion checker for ppodc_top, bound to its ports.
   Assumes one clock, synchronous active-high reset, ce_i gating all state. */
`timescale 1ns/1ps
`default_nettype none
// ------
// Checker
// ------
module ppodc_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Bus
    input wire ppodc_pkg::ppodc_wb_req_t wb_req_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Pads
    input wire logic osc_claims_pins_i,
    input wire logic [6:0] port_pin_oe_o,
    input wire logic rtc_pin_output_en_i,
    input wire logic rtc_pin_o,
    input wire logic rtc_pin_oe_o,
    input wire logic charge_unit_delay_input_en_o,
    input wire logic charge_unit_delay_o
);
    import ppodc_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // One request accepted by the slave
    sequence bus_take;
        ce_i && wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    endsequence
    // Bus handshake and read data
    ack_follows_take_a: assert property (bus_take |=> wb_ack_o)
        else $error("request not acknowledged one cycle later");
    ack_single_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_has_cause_a: assert property ($rose(wb_ack_o)
        |-> $past(ce_i && wb_req_i.cyc && wb_req_i.stb && !wb_ack_o))
        else $error("ack without a request");
    dat_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    // Clock pin gating follows the clock block enable only
    rtc_oe_follow_a: assert property (ce_i |=> rtc_pin_oe_o == $past(rtc_pin_output_en_i))
        else $error("clock pin enable does not follow its enable input");
    rtc_pin_quiet_a: assert property (!rtc_pin_oe_o |-> !rtc_pin_o)
        else $error("clock pin toggles while disabled");
    // Oscillator pins never driven by the port
    osc_pins_free_a: assert property (ce_i && osc_claims_pins_i |=> (port_pin_oe_o & 7'h50) == 7'h0)
        else $error("port drives a pin owned by the oscillator");
    delay_needs_en_a: assert property (charge_unit_delay_o |-> charge_unit_delay_input_en_o)
        else $error("delay input active while routing disabled");
endmodule

bind ppodc_top ppodc_chk u_chk (.clk_i, .rst_i, .ce_i, .wb_req_i, .wb_ack_o, .wb_dat_o,
    .osc_claims_pins_i, .port_pin_oe_o, .rtc_pin_output_en_i, .rtc_pin_o, .rtc_pin_oe_o,
    .charge_unit_delay_input_en_o, .charge_unit_delay_o);
`default_nettype wire

// file: testbench/ppodc_pins.sv
/* Model of the first port's board: external pull-ups and an outside driver.
   Assumes the outside driver overpowers the pad when enabled. */
`timescale 1ns/1ps
`default_nettype none
// ------
// Pin model
// ------
module ppodc_pins (
    // Pad side
    input wire logic [6:0] pin_out_i,
    input wire logic [6:0] pin_oe_i,
    // Outside driver
    input wire logic [6:0] ext_val_i,
    input wire logic [6:0] ext_en_i,
    // Resolved level
    output logic [6:0] pin_lvl_o
);
    // Released lines go high through the pull-ups, never keep the last value
    assign pin_lvl_o = (ext_en_i & ext_val_i) | (~ext_en_i & ~pin_oe_i)
        | (~ext_en_i & pin_oe_i & pin_out_i);
endmodule
`default_nettype wire

// file: testbench/tb.sv
/* Self-checking bench for ppodc_top: register table, port, pads, clock pin.
   Assumes the pin model in ppodc_pins.sv and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
// ------
// Bench
// ------
module tb;
    import ppodc_pkg::*;
    typedef struct packed {logic [11:0] idx; logic [7:0] wd; logic [7:0] rd;} ppodc_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    ppodc_wb_req_t wb_req_i = '0;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic [6:0] port_pin_i, port_pin_o, port_pin_oe_o, ext_val = '0, ext_en = '0;
    logic osc_claims_pins_i = 1'b0;
    logic comparator_on_i = 1'b0;
    logic [15:0] periph_out_i = '0, periph_drive_i = '0, remap_pad_o, remap_pad_oe_o;
    logic [63:0] remap_sel_i = '0;
    ppodc_rtc_src_t rtc_src_i = '0;
    logic rtc_pin_output_en_i = 1'b0;
    logic rtc_pin_o, rtc_pin_oe_o, parallel_port_ttl_select_o;
    logic charge_unit_delay_input_en_o, charge_unit_delay_o;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] q;
    // Write value beside expected read-back; unimplemented bits must vanish
    ppodc_row_t rows [7] = '{'{12'hf42, 8'hff, 8'hff}, '{12'hf42, 8'ha5, 8'ha5},
        '{12'hf41, 8'hff, 8'h0f}, '{12'hf40, 8'hff, 8'h83}, '{12'hf3c, 8'hff, 8'h07},
        '{12'hf44, 8'h55, 8'h55}, '{12'hf45, 8'h7f, 8'h7f}};

    always #4 clk_i = ~clk_i;

    ppodc_top dut (.clk_i, .rst_i, .ce_i, .wb_req_i, .wb_ack_o, .wb_dat_o, .port_pin_i,
        .port_pin_o, .port_pin_oe_o, .osc_claims_pins_i, .comparator_on_i, .periph_out_i,
        .periph_drive_i, .remap_sel_i, .remap_pad_o, .remap_pad_oe_o, .rtc_src_i,
        .rtc_pin_output_en_i, .rtc_pin_o, .rtc_pin_oe_o, .parallel_port_ttl_select_o,
        .charge_unit_delay_input_en_o, .charge_unit_delay_o);

    ppodc_pins board (.pin_out_i(port_pin_o), .pin_oe_i(port_pin_oe_o), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .pin_lvl_o(port_pin_i));

    task automatic end_sim;
        begin
            if (mismatches == 0 && samples_checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            samples_checked++;
            if (got !== exp)
            begin
                mismatches++;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Classic single cycle; held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d,
        input logic [3:0] s);
        begin
            wb_req_i <= '{1'b1, 1'b1, w, {a, 2'b00}, s, {24'h0, d}};
            // Waits as long as the slave needs; only the hang guard ends a wait
            do
                @(posedge clk_i);
            while (wb_ack_o !== 1'b1);
            q = wb_dat_o;
            wb_req_i.cyc <= 1'b0;
            wb_req_i.stb <= 1'b0;
            @(posedge clk_i);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'h1);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        begin
            wb(1'b0, a, 8'h00, 4'h1);
            chk(q, exp);
        end
    endtask

    // Lets pin synchronisers and registered pads settle
    task automatic st;
        repeat (4) @(posedge clk_i);
    endtask

    // Hang guard, well above the expected run length
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            end_sim();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i])
        begin
            wr(rows[i].idx, rows[i].wd);
            rdc(rows[i].idx, {24'h0, rows[i].rd});
        end
        // Second reset in mid-run clears everything again except the direction, which returns to all inputs
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) rdc(rows[i].idx, (rows[i].idx == 12'hf45) ? 32'h7f : 32'h0);
        rdc(12'hf46, 32'h0);
        rdc(12'hf43, 32'h50);
        wr(12'hf50, 8'hff);
        rdc(12'hf50, 32'h0);
        wb(1'b1, 12'hf42, 8'hff, 4'h0);
        rdc(12'hf42, 32'h0);
        // Digital port driven from the latch, then overpowered from outside
        wr(12'hf46, 8'h2f);
        wr(12'hf45, 8'h00);
        wr(12'hf43, 8'h35);
        st();
        chk({port_pin_oe_o, port_pin_o}, {7'h7f, 7'h35});
        ext_en <= 7'h7f;
        ext_val <= 7'h0a;
        st();
        rdc(12'hf43, 32'h0a);
        rdc(12'hf44, 32'h35);
        ext_en <= 7'h00;
        wr(12'hf45, 8'h7f);
        st();
        chk({25'h0, port_pin_oe_o}, 32'h0);
        rdc(12'hf43, 32'h7f);
        comparator_on_i <= 1'b1;
        st();
        rdc(12'hf43, 32'h50);
        comparator_on_i <= 1'b0;
        osc_claims_pins_i <= 1'b1;
        st();
        rdc(12'hf43, 32'h2f);
        wr(12'hf45, 8'h00);
        st();
        chk({25'h0, port_pin_oe_o}, 32'h2f);
        osc_claims_pins_i <= 1'b0;
        wr(12'hf46, 8'h00);
        st();
        chk({25'h0, port_pin_oe_o}, 32'h7f);
        rdc(12'hf43, 32'h10);
        wr(12'hf45, 8'h7f);
        // Delay input routed from pin one
        wr(12'hf40, 8'h80);
        st();
        chk({30'h0, charge_unit_delay_input_en_o, charge_unit_delay_o}, 32'h3);
        ext_en <= 7'h02;
        ext_val <= 7'h00;
        st();
        chk({31'h0, charge_unit_delay_o}, 32'h0);
        ext_en <= 7'h00;
        // Every clock select code, sources set so a wrong pick shows
        rtc_pin_output_en_i <= 1'b1;
        for (int c = 0; c < 8; c++)
        begin
            rtc_src_i <= c[2] ? (3'b100 >> c[1:0]) : ~(3'b100 >> c[1:0]);
            wr(12'hf3c, {5'h0, c[1:0], c[2]});
            st();
            chk({rtc_pin_oe_o, rtc_pin_o, parallel_port_ttl_select_o},
                {1'b1, c[2] && (c[1:0] != 2'h3), c[2]});
        end
        rtc_src_i <= 3'b111;
        wr(12'hf3c, 8'h00);
        rtc_pin_output_en_i <= 1'b0;
        st();
        chk({rtc_pin_oe_o, rtc_pin_o}, 2'h0);
        // Remapped pads, identity first, then shifted by one
        for (int g = 0; g < 16; g++) remap_sel_i[4*g +: 4] <= g[3:0];
        periph_drive_i <= 16'hffff;
        periph_out_i <= 16'hffff;
        wr(12'hf42, 8'hff);
        wr(12'hf41, 8'h0f);
        wr(12'hf40, 8'h03);
        st();
        chk({remap_pad_o, remap_pad_oe_o}, 32'h0);
        periph_out_i <= 16'h0000;
        st();
        chk({remap_pad_o, remap_pad_oe_o}, 32'h0000ffff);
        wr(12'hf42, 8'h01);
        wr(12'hf41, 8'h00);
        wr(12'hf40, 8'h00);
        periph_out_i <= 16'hffff;
        for (int g = 0; g < 16; g++) remap_sel_i[4*g +: 4] <= g[3:0] + 4'h1;
        st();
        chk({remap_pad_o, remap_pad_oe_o}, 32'h7fff7fff);
        // Clock enable low freezes the pads; raising it lets them follow again
        ce_i <= 1'b0;
        rtc_pin_output_en_i <= 1'b1;
        periph_out_i <= 16'h0000;
        st();
        chk({remap_pad_o, remap_pad_oe_o}, 32'h7fff7fff);
        chk({31'h0, rtc_pin_oe_o}, 32'h0);
        ce_i <= 1'b1;
        st();
        chk({remap_pad_o, remap_pad_oe_o}, 32'h0000ffff);
        chk({31'h0, rtc_pin_oe_o}, 32'h1);
        end_sim();
    end
endmodule
`default_nettype wire

// file: verilog/ppodc_top.sv
/*
 * Pad open-drain control, first general-purpose port and pad configuration.
 * Assumes a Wishbone classic master on the same clock, pins arriving
 * asynchronously, and peripheral and remap signals from this clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ppodc_defines.svh"

module ppodc_top (
    // Clock, reset and clock enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire ppodc_pkg::ppodc_wb_req_t wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // First port pads
    input wire logic [6:0] port_pin_i,
    output logic [6:0] port_pin_o,
    output logic [6:0] port_pin_oe_o,
    input wire logic osc_claims_pins_i,
    input wire logic comparator_on_i,
    // Remappable peripheral pads
    input wire logic [15:0] periph_out_i,
    input wire logic [15:0] periph_drive_i,
    input wire logic [63:0] remap_sel_i,
    output logic [15:0] remap_pad_o,
    output logic [15:0] remap_pad_oe_o,
    // Real-time-clock pin
    input wire ppodc_pkg::ppodc_rtc_src_t rtc_src_i,
    input wire logic rtc_pin_output_en_i,
    output logic rtc_pin_o,
    output logic rtc_pin_oe_o,
    // Pad configuration outputs
    output logic parallel_port_ttl_select_o,
    output logic charge_unit_delay_input_en_o,
    output logic charge_unit_delay_o
);
    import ppodc_pkg::*;

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    logic [7:0] pad_cfg_q;
    logic [7:0] od_ser_q;
    logic [7:0] od_hi_q;
    logic [7:0] od_cmp_q;
    logic [6:0] latch_q;
    logic [6:0] dir_q;
    logic [6:0] ancfg_q;
    logic [6:0] pin_meta_q;
    logic [6:0] pin_sync_q;
    logic ack_q;
    logic [31:0] rd_q;
    logic [31:0] rd_d;
    logic [11:0] idx;
    logic wr_en;
    logic rd_en;
    logic [6:0] claimed;
    logic [6:0] analog;
    logic [6:0] pin_digital;
    logic [15:0] od_en;
    logic [1:0] rtc_sel;
    logic rtc_d;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------

    // Word index; low two address bits are byte lanes within the word
    assign idx = wb_req_i.adr[13:2];

    // A request is served once; ack_q blocks a second hit on the held request
    assign rd_en = ce_i & wb_req_i.cyc & wb_req_i.stb & ~ack_q;

    // Registers live in byte lane 0, so only that lane writes them
    assign wr_en = rd_en & wb_req_i.we & wb_req_i.sel[0];

    // ------------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------------

    // Two stages before any logic reads the pads
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta_q <= 7'h00;
            pin_sync_q <= 7'h00;
        end
        else if (ce_i)
        begin
            pin_meta_q <= port_pin_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ------------------------------------------------------------------------
    // Port pin qualification
    // ------------------------------------------------------------------------

    // Oscillator may take two pins, leaving a five-bit port
    assign claimed = osc_claims_pins_i ? `PPODC_OSC_PINS : 7'h00;

    // Config bit 0 means analog, so reset leaves capable pins analog
    assign analog = ~ancfg_q & `PPODC_ANA_PINS;

    // Analog pins, claimed pins and comparator-held pins read as zero.
    // Software is expected to stop the comparators first; this only
    // makes the reads deterministic if it does not.
    always_comb
    begin
        pin_digital = pin_sync_q & ~analog & ~claimed;
        if (comparator_on_i)
        begin
            pin_digital = pin_digital & ~`PPODC_ANA_PINS;
        end
    end

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------

    // Open-drain and pad config; masks drop unimplemented bits on write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pad_cfg_q <= `PPODC_RST_CTRL;
            od_ser_q <= `PPODC_RST_CTRL;
            od_hi_q <= `PPODC_RST_CTRL;
            od_cmp_q <= `PPODC_RST_CTRL;
        end
        else if (wr_en)
        begin
            case (idx)
                `PPODC_IDX_PADCFG:
                    pad_cfg_q <= wb_req_i.dat[7:0] & `PPODC_MASK_PADCFG;
                `PPODC_IDX_OD_SER:
                    od_ser_q <= wb_req_i.dat[7:0] & `PPODC_MASK_OD_SER;
                `PPODC_IDX_OD_HI:
                    od_hi_q <= wb_req_i.dat[7:0] & `PPODC_MASK_OD_HI;
                `PPODC_IDX_OD_CMP:
                    od_cmp_q <= wb_req_i.dat[7:0] & `PPODC_MASK_OD_CMP;
                default:
                    od_cmp_q <= od_cmp_q;
            endcase
        end
    end

    // Port registers; a write to the port address lands in the latch
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            latch_q <= `PPODC_RST_LATCH;
            dir_q <= `PPODC_RST_DIR;
            ancfg_q <= `PPODC_RST_ANCFG;
        end
        else if (wr_en)
        begin
            case (idx)
                `PPODC_IDX_PORT:
                    latch_q <= wb_req_i.dat[6:0];
                `PPODC_IDX_LATCH:
                    latch_q <= wb_req_i.dat[6:0];
                `PPODC_IDX_DIR:
                    dir_q <= wb_req_i.dat[6:0];
                `PPODC_IDX_ANCFG:
                    ancfg_q <= wb_req_i.dat[6:0] & `PPODC_ANA_PINS;
                default:
                    latch_q <= latch_q;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------

    // Unmapped addresses still ack, with zero data, so the bus never hangs
    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (idx)
            `PPODC_IDX_PADCFG:
                rd_d[7:0] = pad_cfg_q;
            `PPODC_IDX_OD_SER:
                rd_d[7:0] = od_ser_q;
            `PPODC_IDX_OD_HI:
                rd_d[7:0] = od_hi_q;
            `PPODC_IDX_OD_CMP:
                rd_d[7:0] = od_cmp_q;
            `PPODC_IDX_PORT:
                rd_d[6:0] = pin_digital;
            `PPODC_IDX_LATCH:
                rd_d[6:0] = latch_q;
            `PPODC_IDX_DIR:
                rd_d[6:0] = dir_q;
            `PPODC_IDX_ANCFG:
                rd_d[6:0] = ancfg_q;
            default:
                rd_d = 32'h0000_0000;
        endcase
    end

    // One-cycle ack, dropped in the cycle after it was given
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rd_q <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            ack_q <= rd_en;
            if (rd_en)
            begin
                rd_q <= rd_d;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_q;

    // ------------------------------------------------------------------------
    // First port drivers
    // ------------------------------------------------------------------------

    // Direction acts even on analog pins; claimed pins are let go
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            port_pin_o <= 7'h00;
            port_pin_oe_o <= 7'h00;
        end
        else if (ce_i)
        begin
            port_pin_o <= latch_q;
            port_pin_oe_o <= ~dir_q & ~claimed;
        end
    end

    // ------------------------------------------------------------------------
    // Open-drain enables per peripheral output
    // ------------------------------------------------------------------------

    // Serial-peripheral ports use two entries each: data then clock
    assign od_en = {
        od_ser_q[1], od_ser_q[1],
        od_ser_q[0], od_ser_q[0],
        od_hi_q[3:0],
        od_cmp_q
    };

    // ------------------------------------------------------------------------
    // Remappable pads
    // ------------------------------------------------------------------------

    // Each pad takes its peripheral, and that peripheral's open-drain bit,
    // from the remap select, so the option follows the pin assignment.
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1)
        begin : g_pad
            logic [3:0] src;
            logic val;
            logic odm;
            assign src = remap_sel_i[g*4 +: 4];
            assign val = periph_out_i[src];
            assign odm = od_en[src];
            // Open-drain: drive low only, release on high
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    remap_pad_o[g] <= 1'b0;
                    remap_pad_oe_o[g] <= 1'b0;
                end
                else if (ce_i)
                begin
                    remap_pad_o[g] <= odm ? 1'b0 : val;
                    remap_pad_oe_o[g] <= periph_drive_i[src] & ~(odm & val);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Real-time-clock pin
    // ------------------------------------------------------------------------

    assign rtc_sel = pad_cfg_q[`PPODC_RTC_SEL_HI:`PPODC_RTC_SEL_LO];

    // Reserved code drives low rather than an undefined source
    always_comb
    begin
        case (rtc_sel)
            `PPODC_RTC_ALARM:
                rtc_d = rtc_src_i.alarm;
            `PPODC_RTC_SEC:
                rtc_d = rtc_src_i.seconds;
            `PPODC_RTC_SRC:
                rtc_d = rtc_src_i.source;
            default:
                rtc_d = 1'b0;
        endcase
    end

    // The select alone never enables the pin
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rtc_pin_o <= 1'b0;
            rtc_pin_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            rtc_pin_o <= rtc_d & rtc_pin_output_en_i;
            rtc_pin_oe_o <= rtc_pin_output_en_i;
        end
    end

    // ------------------------------------------------------------------------
    // Pad configuration outputs
    // ------------------------------------------------------------------------

    // Delay input uses the raw synchronised level: analog mode on that
    // pin only blocks the port read, not this peripheral path.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            parallel_port_ttl_select_o <= 1'b0;
            charge_unit_delay_input_en_o <= 1'b0;
            charge_unit_delay_o <= 1'b0;
        end
        else if (ce_i)
        begin
            parallel_port_ttl_select_o <= pad_cfg_q[`PPODC_BIT_TTL];
            charge_unit_delay_input_en_o <= od_ser_q[`PPODC_BIT_DELAY_EN];
            charge_unit_delay_o <= od_ser_q[`PPODC_BIT_DELAY_EN]
                & pin_sync_q[`PPODC_DELAY_PIN];
        end
    end

endmodule
`default_nettype wire
